// File: src/can_cfg_regs.svh
// register offsets, field positions, reset values and timing counts of the can configuration block
`ifndef CAN_CFG_REGS_SVH
`define CAN_CFG_REGS_SVH

`define ADDR_W 12
`define OFF_INT_ENABLE 12'h000
`define OFF_INT_STATUS 12'h004
`define OFF_ERR_COUNT 12'h008
`define OFF_PRESCALE 12'h00C
`define OFF_SEGMENTS 12'h010
`define OFF_FILTER_EN 12'h014
`define OFF_DEST_G0 12'h018
`define OFF_DEST_G1 12'h01C
`define OFF_DEST_G2 12'h020
`define OFF_DEST_G3 12'h024
`define OFF_CLOCK_SEL 12'h028

`define IRQ_BITS_MASK 8'hEF
`define IRQ_BAD_MSG 7
`define IRQ_WAKEUP 6
`define IRQ_FAULT 5
`define IRQ_QUEUE_FULL 3
`define IRQ_RX_OVERRUN 2
`define IRQ_RX_BUFFER 1
`define IRQ_TX_BUFFER 0

`define SJW_MSB 7
`define SJW_LSB 6
`define BRP_MSB 5
`define BRP_LSB 0
`define WAKE_FILT_BIT 14
`define PH2_MSB 10
`define PH2_LSB 8
`define PH2_PROG_BIT 7
`define TRIPLE_BIT 6
`define PH1_MSB 5
`define PH1_LSB 3
`define PROP_MSB 2
`define PROP_LSB 0
`define SEGMENTS_MASK 16'h47FF
`define DEST_FIFO 4'hF

`define RST_INT_ENABLE 8'h00
`define RST_PRESCALE 8'h00
`define RST_SEGMENTS 16'h0000
`define RST_FILTER_EN 16'h003F
`define RST_DEST 16'h0000
`define RST_CLOCK_SEL 1'b0

`define PROCESSING_TIME_TQ 4'h2
`define WAKE_FILTER_NS 200
`define CLK_PERIOD_NS 40
`define WAKE_FILTER_CYCLES ((`WAKE_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: src/can_cfg_pkg.sv
// types shared by the can configuration block
package can_cfg_pkg;

    typedef struct packed {
        logic bad_message;
        logic wakeup;
        logic fault;
        logic unused4;
        logic queue_nearly_full;
        logic rx_overrun;
        logic rx_buffer;
        logic tx_buffer;
    } irq_events_t;

    typedef struct packed {
        logic to_fifo;
        logic [3:0] buffer;
        logic [3:0] filter;
    } route_t;

    typedef struct packed {
        logic [7:0] tx_fault_count;
        logic [7:0] rx_fault_count;
    } fault_counts_t;

    typedef enum logic [3:0] {
        SEG_SYNC = 4'h1,
        SEG_PROP = 4'h2,
        SEG_PHASE1 = 4'h4,
        SEG_PHASE2 = 4'h8
    } seg_state_t;

endpackage

// File: src/can_timing_filter_routing.sv
// can configuration, bit timing, wake-up filter, interrupt and filter routing block
// Notes on behaviour
// - interrupt enables for bad message, wake-up, fault at bits 7..5, reset zero
// - enables for queue full, overrun, rx, tx at bits 3..0; bit 4 reads zero
// - upper bits of enable and prescale registers read zero, writes ignored
// - error counts: transmit in bits 15..8, receive in 7..0, read-only, reset zero
// - jump width field 00..11 limits resynchronisation to one..four quanta
// - quantum equals two times (prescaler plus one) module clock periods
// - clock select bit chooses instruction clock when set, oscillator clock when clear
// - phase two length is field plus one quanta, one to eight
// - phase one length is field plus one quanta, one to eight
// - propagation length is field plus one quanta, one to eight
// - phase two programmable when select set, else max of phase one and processing time
// - triple sample bit set: majority of three samples, else single sample
// - wake-up filter bit set routes wake-up detection through the line filter
// - sixteen filter enables, filters 0..5 enabled after reset
// - destination 1111 routes to fifo, 0000..1110 to buffers 0..14
// - four destinations per register, lowest filter in the low nibble
// - each enable pairs with a software-cleared status flag at the same bit
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "can_cfg_regs.svh"

module can_timing_filter_routing
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic instruction_clock,
    input wire logic oscillator_clock,
    input wire logic can_rx,
    input wire can_cfg_pkg::irq_events_t events,
    input wire can_cfg_pkg::fault_counts_t fault_counts,
    input wire logic filter_hit_valid,
    input wire logic [3:0] filter_hit_index,
    output logic irq,
    output logic time_quantum,
    output logic bit_start,
    output logic sample_strobe,
    output logic sampled_bit,
    output logic wakeup_detect,
    output logic route_valid,
    output can_cfg_pkg::route_t route
);

    logic [7:0] int_enable;
    logic [7:0] int_status;
    can_cfg_pkg::fault_counts_t err_count;
    logic [7:0] prescale;
    logic [15:0] segments;
    logic [15:0] filter_accept_en;
    logic [15:0] dest_group [4];
    logic clock_sel;

    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic [15:0] wmask;
    logic [15:0] wval;
    logic [7:0] status_clear;

    logic rx_meta;
    logic rx_sync;
    logic rx_prev;
    logic rx_fall;

    logic module_clock;
    logic [6:0] tq_cnt;
    logic tq_tick;
    can_cfg_pkg::seg_state_t seg_state;
    logic [3:0] seg_cnt;
    logic [3:0] ph1_ext;
    logic [3:0] ph2_cut;
    logic resynced;
    logic [2:0] sample_hist;
    logic [3:0] ph2_len;
    logic [3:0] sjw_q;
    logic [3:0] ph1_len;
    logic [3:0] prop_len;

    logic [$clog2(`WAKE_FILTER_CYCLES + 1) - 1:0] wake_cnt;
    logic wake_filtered;
    logic wake_seen;

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a[1:0] == 2'h0) && (a <= `OFF_CLOCK_SEL);
    endfunction

    // dest nibble of filter n from the packed groups
    function automatic logic [3:0] dest_of(input logic [3:0] n, input logic [15:0] g0, input logic [15:0] g1,
                                           input logic [15:0] g2, input logic [15:0] g3);
        logic [15:0] g;
        case (n[3:2])
            2'h0: g = g0;
            2'h1: g = g1;
            2'h2: g = g2;
            default: g = g3;
        endcase
        dest_of = g[n[1:0] * 4 +: 4];
    endfunction

    // ---------------- axi4-lite write channel ----------------
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
    assign wval = w_data[15:0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // software-written configuration registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            int_enable <= `RST_INT_ENABLE;
            prescale <= `RST_PRESCALE;
            segments <= `RST_SEGMENTS;
            filter_accept_en <= `RST_FILTER_EN;
            clock_sel <= `RST_CLOCK_SEL;
            for (int i = 0; i < 4; i++)
            begin
                dest_group[i] <= `RST_DEST;
            end
        end
        else if (do_write)
        begin
            case (aw_addr)
                `OFF_INT_ENABLE: int_enable <= ((int_enable & ~wmask[7:0]) | (wval[7:0] & wmask[7:0])) & `IRQ_BITS_MASK;
                `OFF_PRESCALE: prescale <= (prescale & ~wmask[7:0]) | (wval[7:0] & wmask[7:0]);
                `OFF_SEGMENTS: segments <= ((segments & ~wmask) | (wval & wmask)) & `SEGMENTS_MASK;
                `OFF_FILTER_EN: filter_accept_en <= (filter_accept_en & ~wmask) | (wval & wmask);
                `OFF_DEST_G0: dest_group[0] <= (dest_group[0] & ~wmask) | (wval & wmask);
                `OFF_DEST_G1: dest_group[1] <= (dest_group[1] & ~wmask) | (wval & wmask);
                `OFF_DEST_G2: dest_group[2] <= (dest_group[2] & ~wmask) | (wval & wmask);
                `OFF_DEST_G3: dest_group[3] <= (dest_group[3] & ~wmask) | (wval & wmask);
                `OFF_CLOCK_SEL: clock_sel <= w_strb[0] ? wval[0] : clock_sel;
                default: clock_sel <= clock_sel;
            endcase
        end
    end

    // ---------------- status flags and interrupt ----------------
    assign status_clear = (do_write && aw_addr == `OFF_INT_STATUS && w_strb[0]) ? wval[7:0] : 8'h00;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            int_status <= 8'h00;
        end
        else
        begin
            int_status <= ((int_status & ~status_clear) | events | {1'b0, wake_seen, 6'h00}) & `IRQ_BITS_MASK;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(int_status & int_enable);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            err_count <= '0;
        end
        else
        begin
            err_count <= fault_counts;
        end
    end

    // ---------------- axi4-lite read channel ----------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            case (s_axi_araddr)
                `OFF_INT_ENABLE: s_axi_rdata <= {24'h000000, int_enable};
                `OFF_INT_STATUS: s_axi_rdata <= {24'h000000, int_status};
                `OFF_ERR_COUNT: s_axi_rdata <= {16'h0000, err_count};
                `OFF_PRESCALE: s_axi_rdata <= {24'h000000, prescale};
                `OFF_SEGMENTS: s_axi_rdata <= {16'h0000, segments};
                `OFF_FILTER_EN: s_axi_rdata <= {16'h0000, filter_accept_en};
                `OFF_DEST_G0: s_axi_rdata <= {16'h0000, dest_group[0]};
                `OFF_DEST_G1: s_axi_rdata <= {16'h0000, dest_group[1]};
                `OFF_DEST_G2: s_axi_rdata <= {16'h0000, dest_group[2]};
                `OFF_DEST_G3: s_axi_rdata <= {16'h0000, dest_group[3]};
                `OFF_CLOCK_SEL: s_axi_rdata <= {31'h00000000, clock_sel};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ---------------- bus line synchroniser ----------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            rx_prev <= 1'b1;
        end
        else
        begin
            rx_meta <= can_rx;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
        end
    end

    assign rx_fall = rx_prev && !rx_sync;

    // ---------------- quantum generator ----------------
    // tick source choice
    assign module_clock = clock_sel ? instruction_clock : oscillator_clock;
    assign tq_tick = module_clock && (tq_cnt == {prescale[`BRP_MSB:`BRP_LSB], 1'b1});

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tq_cnt <= 7'h00;
            time_quantum <= 1'b0;
        end
        else
        begin
            time_quantum <= tq_tick;
            if (tq_tick)
            begin
                tq_cnt <= 7'h00;
            end
            else if (module_clock)
            begin
                tq_cnt <= tq_cnt + 7'h01;
            end
        end
    end

    // ---------------- bit segment sequencer ----------------
    // jump width in quanta
    assign sjw_q = {2'h0, prescale[`SJW_MSB:`SJW_LSB]} + 4'h1;
    assign prop_len = {1'b0, segments[`PROP_MSB:`PROP_LSB]} + 4'h1;
    // phase one length plus resync extension
    assign ph1_len = {1'b0, segments[`PH1_MSB:`PH1_LSB]} + 4'h1 + ph1_ext;

    always_comb
    begin
        if (segments[`PH2_PROG_BIT])
        begin
            ph2_len = {1'b0, segments[`PH2_MSB:`PH2_LSB]} + 4'h1;
        end
        else if ({1'b0, segments[`PH1_MSB:`PH1_LSB]} + 4'h1 > `PROCESSING_TIME_TQ)
        begin
            ph2_len = {1'b0, segments[`PH1_MSB:`PH1_LSB]} + 4'h1;
        end
        else
        begin
            ph2_len = `PROCESSING_TIME_TQ;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            seg_state <= can_cfg_pkg::SEG_SYNC;
            seg_cnt <= 4'h0;
            ph1_ext <= 4'h0;
            ph2_cut <= 4'h0;
            resynced <= 1'b0;
            bit_start <= 1'b0;
        end
        else
        begin
            bit_start <= 1'b0;
            // one resync per bit, limited by jump width
            if (rx_fall && !resynced && seg_state != can_cfg_pkg::SEG_SYNC)
            begin
                resynced <= 1'b1;
                if (seg_state == can_cfg_pkg::SEG_PHASE2)
                begin
                    ph2_cut <= sjw_q;
                end
                else
                begin
                    ph1_ext <= sjw_q;
                end
            end
            if (tq_tick)
            begin
                // sync, prop, phase one, phase two
                case (seg_state)
                    can_cfg_pkg::SEG_SYNC:
                    begin
                        seg_state <= can_cfg_pkg::SEG_PROP;
                        seg_cnt <= 4'h0;
                        bit_start <= 1'b1;
                    end
                    can_cfg_pkg::SEG_PROP:
                    begin
                        seg_cnt <= (seg_cnt == prop_len - 4'h1) ? 4'h0 : seg_cnt + 4'h1;
                        if (seg_cnt == prop_len - 4'h1)
                        begin
                            seg_state <= can_cfg_pkg::SEG_PHASE1;
                        end
                    end
                    can_cfg_pkg::SEG_PHASE1:
                    begin
                        seg_cnt <= (seg_cnt == ph1_len - 4'h1) ? 4'h0 : seg_cnt + 4'h1;
                        if (seg_cnt == ph1_len - 4'h1)
                        begin
                            seg_state <= can_cfg_pkg::SEG_PHASE2;
                        end
                    end
                    can_cfg_pkg::SEG_PHASE2:
                    begin
                        seg_cnt <= seg_cnt + 4'h1;
                        if ({1'b0, seg_cnt} + 5'h01 + {1'b0, ph2_cut} >= {1'b0, ph2_len})
                        begin
                            seg_state <= can_cfg_pkg::SEG_SYNC;
                            seg_cnt <= 4'h0;
                            ph1_ext <= 4'h0;
                            ph2_cut <= 4'h0;
                            resynced <= 1'b0;
                        end
                    end
                    default:
                    begin
                        seg_state <= can_cfg_pkg::SEG_SYNC;
                        seg_cnt <= 4'h0;
                    end
                endcase
            end
        end
    end

    // ---------------- sample point ----------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sample_hist <= 3'h7;
            sample_strobe <= 1'b0;
            sampled_bit <= 1'b1;
        end
        else
        begin
            sample_strobe <= 1'b0;
            if (module_clock)
            begin
                sample_hist <= {sample_hist[1:0], rx_sync};
            end
            if (tq_tick && seg_state == can_cfg_pkg::SEG_PHASE1 && seg_cnt == ph1_len - 4'h1)
            begin
                sample_strobe <= 1'b1;
                if (segments[`TRIPLE_BIT])
                begin
                    sampled_bit <= (sample_hist[0] & sample_hist[1]) | (sample_hist[1] & sample_hist[2])
                                   | (sample_hist[0] & sample_hist[2]);
                end
                else
                begin
                    sampled_bit <= rx_sync;
                end
            end
        end
    end

    // ---------------- wake-up detection ----------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wake_cnt <= '0;
            wake_filtered <= 1'b0;
        end
        else if (rx_sync)
        begin
            wake_cnt <= '0;
            wake_filtered <= 1'b0;
        end
        else if (wake_cnt == ($bits(wake_cnt))'(`WAKE_FILTER_CYCLES))
        begin
            wake_filtered <= 1'b1;
        end
        else
        begin
            wake_cnt <= wake_cnt + 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wake_seen <= 1'b0;
            wakeup_detect <= 1'b0;
        end
        else
        begin
            wake_seen <= segments[`WAKE_FILT_BIT] ? (wake_filtered && !wakeup_detect) : (rx_fall);
            wakeup_detect <= segments[`WAKE_FILT_BIT] ? wake_filtered : !rx_sync;
        end
    end

    // ---------------- filter hit routing ----------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            route_valid <= 1'b0;
            route <= '0;
        end
        else
        begin
            route_valid <= filter_hit_valid && filter_accept_en[filter_hit_index];
            route.filter <= filter_hit_index;
            route.buffer <= dest_of(filter_hit_index, dest_group[0], dest_group[1], dest_group[2], dest_group[3]);
            route.to_fifo <= dest_of(filter_hit_index, dest_group[0], dest_group[1], dest_group[2],
                                     dest_group[3]) == `DEST_FIFO;
        end
    end

endmodule

// File: test/can_node_model.sv
// far-side bus node that drives the receive line
`timescale 1ns/1ps
module can_node_model
(
    input wire logic dominant,
    output logic can_rx
);
    // released line is pulled recessive
    assign can_rx = dominant ? 1'h0 : 1'h1;
endmodule

// File: test/can_cfg_asserts.sv
// port checks for the can configuration block
`timescale 1ns/1ps
module can_cfg_asserts
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic filter_hit_valid,
    input wire logic [3:0] filter_hit_index,
    input wire logic time_quantum,
    input wire logic bit_start,
    input wire logic sample_strobe,
    input wire logic route_valid,
    input wire can_cfg_pkg::route_t route
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    chk_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while busy");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while busy");
    chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    chk_route_cause: assert property (route_valid |-> $past(filter_hit_valid)
        && route.filter == $past(filter_hit_index))
        else $error("route without matching hit");
    chk_quantum_pulse: assert property (time_quantum |=> !time_quantum)
        else $error("quantum shorter than two ticks");
    chk_sample_apart: assert property (sample_strobe |-> !bit_start)
        else $error("sample point at bit start");
endmodule

bind can_timing_filter_routing can_cfg_asserts i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .filter_hit_valid, .filter_hit_index, .time_quantum, .bit_start, .sample_strobe, .route_valid, .route);

// File: test/can_timing_filter_routing_test.sv
// self-checking bench for the can configuration block
`timescale 1ns/1ps
`include "can_cfg_regs.svh"
module can_timing_filter_routing_test;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0, instruction_clock = 1'h1, oscillator_clock = 1'h0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF, filter_hit_index = 4'h0;
    logic filter_hit_valid = 1'h0, dominant = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, can_rx, irq, time_quantum, bit_start, sample_strobe;
    logic sampled_bit, wakeup_detect, route_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    can_cfg_pkg::irq_events_t events = '0;
    can_cfg_pkg::fault_counts_t fault_counts = '0;
    can_cfg_pkg::route_t route;
    int err_count = 0;
    int checked = 0;

    can_timing_filter_routing i_dut (.*);
    can_node_model i_node (.dominant(dominant), .can_rx(can_rx));

    initial
    begin
        forever #20 aclk = ~aclk;
    end
    always @(posedge aclk) oscillator_clock <= ~oscillator_clock;

    task automatic print_verdict();
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic guard(input bit hung);
        if (hung)
        begin
            err_count++;
            print_verdict();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        rsp = s_axi_bresp;
        guard(n == 50);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        guard(n == 50);
        check(rd, e);
    endtask

    // pulse spacing of quantum or bit start
    task automatic gap(input bit bq, input int exp);
        int n;
        int p;
        int t0;
        p = 0;
        t0 = 0;
        for (n = 0; n < 900; n++)
        begin
            @(posedge aclk);
            if (bq ? bit_start : time_quantum)
            begin
                p++;
                if (p == 2) t0 = n;
            end
            if (p == 3) break;
        end
        guard(n == 900);
        check(n - t0, exp);
    endtask

    task automatic low(input int n, input logic w);
        logic seen;
        seen = 1'h0;
        dominant <= 1'h1;
        repeat (n) @(posedge aclk);
        if (n > 60) check(sampled_bit, 1'h0);
        dominant <= 1'h0;
        repeat (10)
        begin
            @(posedge aclk);
            seen |= wakeup_detect;
        end
        check(seen, w);
    endtask

    task automatic t_defaults();
        rdchk(`OFF_INT_ENABLE, 32'h0);
        rdchk(`OFF_ERR_COUNT, 32'h0);
        rdchk(`OFF_FILTER_EN, 32'h3F);
        rdchk(`OFF_DEST_G3, 32'h0);
        rdchk(12'h02C, 32'h0);
        check(rsp, 32'h2);
        wr(12'h02C, 32'hFF);
        check(rsp, 32'h2);
    endtask

    task automatic t_masks();
        fault_counts <= 16'hA55A;
        wr(`OFF_INT_ENABLE, 32'hFFFFFFFF);
        rdchk(`OFF_INT_ENABLE, 32'hEF);
        wr(`OFF_PRESCALE, 32'hFFFFFFFF);
        rdchk(`OFF_PRESCALE, 32'hFF);
        wr(`OFF_SEGMENTS, 32'hFFFFFFFF);
        rdchk(`OFF_SEGMENTS, 32'h47FF);
        wr(`OFF_ERR_COUNT, 32'hFFFFFFFF);
        rdchk(`OFF_ERR_COUNT, 32'hA55A);
    endtask

    task automatic t_irq();
        wr(`OFF_INT_ENABLE, 32'h04);
        events <= 8'h05;
        @(posedge aclk);
        events <= 8'h00;
        repeat (3) @(posedge aclk);
        check(irq, 32'h1);
        rdchk(`OFF_INT_STATUS, 32'h05);
        wr(`OFF_INT_STATUS, 32'h04);
        repeat (2) @(posedge aclk);
        check(irq, 32'h0);
        rdchk(`OFF_INT_STATUS, 32'h01);
    endtask

    task automatic t_route();
        int f;
        wr(`OFF_FILTER_EN, 32'hFFBF);
        wr(`OFF_DEST_G0, 32'h4321);
        wr(`OFF_DEST_G1, 32'h8765);
        wr(`OFF_DEST_G2, 32'hCBA9);
        wr(`OFF_DEST_G3, 32'hF0ED);
        for (f = 0; f < 16; f++)
        begin
            filter_hit_valid <= 1'h1;
            filter_hit_index <= f[3:0];
            @(posedge aclk);
            filter_hit_valid <= 1'h0;
            @(posedge aclk);
            check(route_valid, f != 6);
            check({route.to_fifo, route.filter}, {f == 15, f[3:0]});
            if (f < 15) check(route.buffer, (f + 1) % 15);
        end
    endtask

    task automatic t_timing();
        wr(`OFF_PRESCALE, 32'h02);
        gap(1'h0, 12);
        wr(`OFF_CLOCK_SEL, 32'h01);
        gap(1'h0, 6);
        wr(`OFF_SEGMENTS, 32'h288);
        gap(1'h1, 42);
        wr(`OFF_SEGMENTS, 32'h018);
        gap(1'h1, 60);
        wr(`OFF_SEGMENTS, 32'h000);
        gap(1'h1, 30);
        wr(`OFF_SEGMENTS, 32'h040);
        low(70, 1'h1);
        wr(`OFF_PRESCALE, 32'h3F);
        gap(1'h0, 128);
    endtask

    task automatic t_wake();
        wr(`OFF_SEGMENTS, 32'h4000);
        wr(`OFF_INT_STATUS, 32'hFF);
        low(3, 1'h0);
        rdchk(`OFF_INT_STATUS, 32'h00);
        low(8, 1'h1);
        rdchk(`OFF_INT_STATUS, 32'h40);
        wr(`OFF_SEGMENTS, 32'h0000);
        wr(`OFF_INT_STATUS, 32'hFF);
        low(1, 1'h1);
        rdchk(`OFF_INT_STATUS, 32'h40);
    endtask

    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        t_defaults();
        t_masks();
        t_irq();
        t_route();
        t_timing();
        t_wake();
        print_verdict();
    end
endmodule
